// *** common/pll_pkg.sv ***
// constants for the pll divider control register slice
package pll_pkg;

   // register indices; byte address is four times the index
   localparam int         IDX_W         = 10;
   localparam logic [9:0] IDX_MODE      = 10'h010;
   localparam logic [9:0] IDX_REF_LOW   = 10'h011;
   localparam logic [9:0] IDX_REF_HIGH  = 10'h012;
   localparam logic [9:0] IDX_SWALLOW   = 10'h013;
   localparam logic [9:0] IDX_FB_LOW    = 10'h014;
   localparam logic [9:0] IDX_FB_HIGH   = 10'h015;
   localparam logic [9:0] IDX_CTRL      = 10'h016;

   // counter and mode field widths
   localparam int REF_W     = 14;
   localparam int SWALLOW_W = 6;
   localparam int FB_W      = 13;
   localparam int MODE_W    = 2;

   // field layout
   localparam int REF_HIGH_W  = REF_W - 8;
   localparam int FB_HIGH_W   = FB_W - 8;
   localparam int PUMP_HALF_BIT = 7;
   localparam int REF_RST_BIT   = 6;
   localparam int FB_RST_BIT    = 5;
   localparam int ALL_RST_BIT   = 4;

   // reset values
   localparam logic [7:0] RST_REF_LOW  = 8'h01;
   localparam logic [7:0] RST_REF_HIGH = 8'h00;
   localparam logic [7:0] RST_SWALLOW  = 8'h00;
   localparam logic [7:0] RST_FB_LOW   = 8'h03;
   localparam logic [7:0] RST_FB_HIGH  = 8'h00;
   localparam logic [1:0] RST_MODE     = 2'h1;
   localparam logic [3:0] RST_CTRL     = 4'h0;

   // operating mode encodings
   localparam logic [1:0] MODE_NORMAL   = 2'h0;
   localparam logic [1:0] MODE_ASYNC_PD = 2'h1;
   localparam logic [1:0] MODE_UNUSED   = 2'h2;
   localparam logic [1:0] MODE_SYNC_PD  = 2'h3;

endpackage

// *** hdl/apb_word_decode.sv ***
// apb address and phase decode for the pll register slice
`timescale 1ns/1ps
module apb_word_decode #(
   parameter int ADDR_W = 12
) (
   // apb request
   input  wire logic [ADDR_W-1:0]     paddr_i,
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   // decode
   output logic                       setup_o,
   output logic                       mapped_o,
   output logic [pll_pkg::IDX_W-1:0]  index_o,
   output logic                       wr_setup_o
);

   function automatic logic is_mapped(input logic [pll_pkg::IDX_W-1:0] idx);
      return (idx >= pll_pkg::IDX_MODE) && (idx <= pll_pkg::IDX_CTRL);
   endfunction

   wire aligned_w = (paddr_i[1:0] == 2'h0);

   assign setup_o    = psel_i & ~penable_i;
   assign index_o    = pll_pkg::IDX_W'(paddr_i[ADDR_W-1:2]);
   assign mapped_o   = aligned_w & is_mapped(index_o);
   assign wr_setup_o = setup_o & pwrite_i & mapped_o;

endmodule

// *** hdl/divider_counter.sv ***
// programmable divide-by-n counter with hold in reset
`timescale 1ns/1ps
module divider_counter #(
   parameter int W = 14
) (
   // clock and reset
   input  wire logic         clock_i,
   input  wire logic         rstn_i,
   // control
   input  wire logic         hold_i,
   input  wire logic         tick_i,
   input  wire logic [W-1:0] divisor_i,
   // result
   output logic              pulse_o,
   output logic [W-1:0]      count_o
);

   // divisor of zero or one divides by one
   wire last_w = (divisor_i <= W'(1)) || (count_o >= divisor_i - W'(1));
   wire [W-1:0] count_next = last_w ? '0 : count_o + W'(1);

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         count_o <= '0;
         pulse_o <= 1'b0;
      end else if (hold_i) begin
         count_o <= '0;
         pulse_o <= 1'b0;
      end else begin
         pulse_o <= tick_i & last_w;
         if (tick_i) begin
            count_o <= count_next;
         end
      end
   end

endmodule

// *** hdl/pll_divider_control_regs.sv ***
// pll divider count and control registers with the dividers they steer
//
// Behaviour
// - the reference divider count is fourteen bits, its low byte at index 0x11 resetting to one.
// - the upper six reference divider bits sit in bits 5:0 at index 0x12, resetting to zero.
// - the six-bit swallow count of the feedback divider sits at index 0x13, resetting to zero.
// - the main feedback count is thirteen bits, its low byte at index 0x14 resetting to three.
// - the upper five main feedback bits sit in bits 4:0 at index 0x15, resetting to zero.
// - control bit 7 at index 0x16 forces the charge pump output to half the pump supply.
// - control bit 5 holds the swallow and main feedback counters in reset.
// - the operating mode field at index 0x10 bits 1:0 lets the pll run only when it is zero.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module pll_divider_control_regs #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic                            clock_i,
   input  wire logic                            rstn_i,
   // apb slave
   input  wire logic [ADDR_W-1:0]               paddr_i,
   input  wire logic                            psel_i,
   input  wire logic                            penable_i,
   input  wire logic                            pwrite_i,
   input  wire logic [31:0]                     pwdata_i,
   output logic      [31:0]                     prdata_o,
   output logic                                 pready_o,
   output logic                                 pslverr_o,
   // divider inputs, one-cycle enables on clock_i
   input  wire logic                            ref_tick_i,
   input  wire logic                            vco_tick_i,
   // pll control outputs
   output logic                                 charge_pump_output_half_o,
   output logic                                 ref_div_reset_o,
   output logic                                 fb_div_reset_o,
   output logic                                 pll_active_o,
   output logic      [pll_pkg::REF_W-1:0]       ref_count_o,
   output logic      [pll_pkg::SWALLOW_W-1:0]   swallow_count_o,
   output logic      [pll_pkg::FB_W-1:0]        fb_count_o,
   // divider outputs
   output logic                                 ref_div_pulse_o,
   output logic                                 fb_div_pulse_o,
   output logic                                 modulus_sel_o
);

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   logic                        setup_w;
   logic                        mapped_w;
   logic                        wr_setup_w;
   logic [pll_pkg::IDX_W-1:0]   index_w;

   apb_word_decode #(
      .ADDR_W (ADDR_W)
   ) u_decode (
      .paddr_i    (paddr_i),
      .psel_i     (psel_i),
      .penable_i  (penable_i),
      .pwrite_i   (pwrite_i),
      .setup_o    (setup_w),
      .mapped_o   (mapped_w),
      .index_o    (index_w),
      .wr_setup_o (wr_setup_w)
   );

   // write takes effect at the access edge that samples pready
   wire access_done_w = psel_i & penable_i & pready_o;
   wire commit_w      = access_done_w & pwrite_i & ~pslverr_o;

   wire wr_mode_w     = commit_w & (index_w == pll_pkg::IDX_MODE);
   wire wr_ref_low_w  = commit_w & (index_w == pll_pkg::IDX_REF_LOW);
   wire wr_ref_high_w = commit_w & (index_w == pll_pkg::IDX_REF_HIGH);
   wire wr_swallow_w  = commit_w & (index_w == pll_pkg::IDX_SWALLOW);
   wire wr_fb_low_w   = commit_w & (index_w == pll_pkg::IDX_FB_LOW);
   wire wr_fb_high_w  = commit_w & (index_w == pll_pkg::IDX_FB_HIGH);
   wire wr_ctrl_w     = commit_w & (index_w == pll_pkg::IDX_CTRL);

   // ------------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------------
   logic [pll_pkg::MODE_W-1:0]  mode_reg;
   logic [3:0]                  ctrl_reg;

   localparam logic [pll_pkg::REF_W-1:0] REF_RESET =
      {pll_pkg::RST_REF_HIGH[pll_pkg::REF_HIGH_W-1:0], pll_pkg::RST_REF_LOW};
   localparam logic [pll_pkg::FB_W-1:0] FB_RESET =
      {pll_pkg::RST_FB_HIGH[pll_pkg::FB_HIGH_W-1:0], pll_pkg::RST_FB_LOW};

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ref_count_o <= REF_RESET;
      end else begin
         if (wr_ref_low_w) begin
            ref_count_o[7:0] <= pwdata_i[7:0];
         end
         if (wr_ref_high_w) begin
            ref_count_o[pll_pkg::REF_W-1:8] <= pwdata_i[pll_pkg::REF_HIGH_W-1:0];
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         swallow_count_o <= pll_pkg::RST_SWALLOW[pll_pkg::SWALLOW_W-1:0];
      end else if (wr_swallow_w) begin
         swallow_count_o <= pwdata_i[pll_pkg::SWALLOW_W-1:0];
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fb_count_o <= FB_RESET;
      end else begin
         if (wr_fb_low_w) begin
            fb_count_o[7:0] <= pwdata_i[7:0];
         end
         if (wr_fb_high_w) begin
            fb_count_o[pll_pkg::FB_W-1:8] <= pwdata_i[pll_pkg::FB_HIGH_W-1:0];
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_reg <= pll_pkg::RST_MODE;
         ctrl_reg <= pll_pkg::RST_CTRL;
      end else begin
         if (wr_mode_w) begin
            mode_reg <= pwdata_i[pll_pkg::MODE_W-1:0];
         end
         if (wr_ctrl_w) begin
            ctrl_reg <= pwdata_i[7:4];
         end
      end
   end

   // ------------------------------------------------------------------
   // read mux, zero above the documented bits
   // ------------------------------------------------------------------
   wire [7:0] ctrl_byte_w = {ctrl_reg, 4'h0};
   wire [7:0] rd_byte_w =
      (index_w == pll_pkg::IDX_MODE)     ? {6'h00, mode_reg} :
      (index_w == pll_pkg::IDX_REF_LOW)  ? ref_count_o[7:0] :
      (index_w == pll_pkg::IDX_REF_HIGH) ? {2'h0, ref_count_o[pll_pkg::REF_W-1:8]} :
      (index_w == pll_pkg::IDX_SWALLOW)  ? {2'h0, swallow_count_o} :
      (index_w == pll_pkg::IDX_FB_LOW)   ? fb_count_o[7:0] :
      (index_w == pll_pkg::IDX_FB_HIGH)  ? {3'h0, fb_count_o[pll_pkg::FB_W-1:8]} :
      (index_w == pll_pkg::IDX_CTRL)     ? ctrl_byte_w :
                                           8'h00;
   wire [31:0] rd_word_w = (setup_w & ~pwrite_i & mapped_w) ? {24'h000000, rd_byte_w} : 32'h00000000;

   // answer prepared in the setup cycle, one access cycle, no wait
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end else begin
         pready_o  <= setup_w;
         pslverr_o <= setup_w & ~mapped_w;
         if (setup_w) begin
            prdata_o <= rd_word_w;
         end
      end
   end

   // ------------------------------------------------------------------
   // control decode
   // ------------------------------------------------------------------
   wire mode_normal_w = (mode_reg == pll_pkg::MODE_NORMAL);
   wire all_hold_w    = ctrl_reg[pll_pkg::ALL_RST_BIT - 4];
   wire ref_hold_w    = ctrl_reg[pll_pkg::REF_RST_BIT - 4] | all_hold_w;
   wire fb_hold_w     = ctrl_reg[pll_pkg::FB_RST_BIT - 4] | all_hold_w;
   wire pump_half_w   = ctrl_reg[pll_pkg::PUMP_HALF_BIT - 4];

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         charge_pump_output_half_o <= 1'b0;
         ref_div_reset_o           <= 1'b0;
         fb_div_reset_o            <= 1'b0;
         pll_active_o              <= 1'b0;
      end else begin
         charge_pump_output_half_o <= pump_half_w;
         ref_div_reset_o           <= ref_hold_w;
         fb_div_reset_o            <= fb_hold_w;
         pll_active_o              <= mode_normal_w;
      end
   end

   // ------------------------------------------------------------------
   // dividers, run only while the pll is active
   // ------------------------------------------------------------------
   wire ref_hold_all_w = ref_div_reset_o | ~pll_active_o;
   wire fb_hold_all_w  = fb_div_reset_o | ~pll_active_o;

   divider_counter #(
      .W (pll_pkg::REF_W)
   ) u_ref_div (
      .clock_i   (clock_i),
      .rstn_i    (rstn_i),
      .hold_i    (ref_hold_all_w),
      .tick_i    (ref_tick_i),
      .divisor_i (ref_count_o),
      .pulse_o   (ref_div_pulse_o),
      .count_o   ()
   );

   divider_counter #(
      .W (pll_pkg::FB_W)
   ) u_fb_div (
      .clock_i   (clock_i),
      .rstn_i    (rstn_i),
      .hold_i    (fb_hold_all_w),
      .tick_i    (vco_tick_i),
      .divisor_i (fb_count_o),
      .pulse_o   (fb_div_pulse_o),
      .count_o   ()
   );

   // swallow phase: higher modulus for the first swallow_count ticks of each cycle
   logic [pll_pkg::SWALLOW_W-1:0] swallow_reg;
   logic [pll_pkg::SWALLOW_W-1:0] swallow_next;
   wire swallowing_w = (swallow_reg < swallow_count_o);

   assign swallow_next = fb_div_pulse_o ? '0 :
                         (vco_tick_i & swallowing_w) ? swallow_reg + pll_pkg::SWALLOW_W'(1) :
                         swallow_reg;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         swallow_reg   <= '0;
         modulus_sel_o <= 1'b0;
      end else if (fb_hold_all_w) begin
         swallow_reg   <= '0;
         modulus_sel_o <= 1'b0;
      end else begin
         swallow_reg   <= swallow_next;
         modulus_sel_o <= swallowing_w;
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   ref_low_write_a: assert property (
      wr_ref_low_w |=> ref_count_o[7:0] == $past(pwdata_i[7:0]))
      else $error("reference low byte not stored");

   ref_high_write_a: assert property (
      wr_ref_high_w |=> ref_count_o[13:8] == $past(pwdata_i[5:0]) && $stable(ref_count_o[7:0]))
      else $error("reference high bits not stored");

   swallow_write_a: assert property (
      wr_swallow_w |=> swallow_count_o == $past(pwdata_i[5:0]))
      else $error("swallow count not stored");

   fb_low_write_a: assert property (
      wr_fb_low_w |=> fb_count_o[7:0] == $past(pwdata_i[7:0]) && $stable(fb_count_o[12:8]))
      else $error("feedback low byte not stored");

   fb_high_write_a: assert property (
      setup_w && pwrite_i && mapped_w && index_w == pll_pkg::IDX_FB_HIGH ##1 psel_i && penable_i
      |=> fb_count_o[12:8] == $past(pwdata_i[4:0], 2))
      else $error("feedback high bits not stored");

   pump_half_a: assert property (
      wr_ctrl_w |=> ##1 charge_pump_output_half_o == $past(pwdata_i[7], 2))
      else $error("charge pump half level does not follow control");

   fb_hold_a: assert property (
      fb_div_reset_o |=> !fb_div_pulse_o && !modulus_sel_o)
      else $error("feedback divider ran while held");

   mode_gate_a: assert property (
      !mode_normal_w [*2] |=> !pll_active_o && !ref_div_pulse_o)
      else $error("pll ran outside normal mode");

   all_hold_a: assert property (
      all_hold_w |=> ref_div_reset_o && fb_div_reset_o)
      else $error("reset all did not hold every counter");

   apb_answer_a: assert property (
      setup_w |=> pready_o && (pslverr_o == !$past(mapped_w)))
      else $error("apb answer missing or wrong");

   mode_write_a: assert property (
      wr_mode_w |=> mode_reg == $past(pwdata_i[1:0]))
      else $error("operating mode not stored");

   ctrl_write_a: assert property (
      wr_ctrl_w |=> ctrl_reg == $past(pwdata_i[7:4]))
      else $error("control bits not stored");

   ref_hold_a: assert property (
      ref_div_reset_o |=> !ref_div_pulse_o)
      else $error("reference divider ran while held");

   swallow_zero_a: assert property (
      swallow_count_o == '0 |=> !modulus_sel_o)
      else $error("modulus select high with no swallow count");

   active_gate_a: assert property (
      !pll_active_o |=> !fb_div_pulse_o && !modulus_sel_o)
      else $error("feedback divider ran while pll inactive");

   refused_write_a: assert property (
      setup_w && pwrite_i && !mapped_w ##1 psel_i && penable_i
      |=> $stable(ref_count_o) && $stable(swallow_count_o) && $stable(fb_count_o)
          && $stable(ctrl_reg) && $stable(mode_reg))
      else $error("refused write changed a register");

   refused_read_a: assert property (
      setup_w && !mapped_w |=> prdata_o == 32'h00000000)
      else $error("refused read returned data");

   ref_read_a: assert property (
      setup_w && !pwrite_i && mapped_w && index_w == pll_pkg::IDX_REF_LOW
      |=> prdata_o == {24'h000000, $past(ref_count_o[7:0])})
      else $error("reference low byte read back wrong");

   swallow_read_a: assert property (
      setup_w && !pwrite_i && mapped_w && index_w == pll_pkg::IDX_SWALLOW
      |=> prdata_o == {26'h0, $past(swallow_count_o)})
      else $error("swallow count read back wrong");

   fb_read_a: assert property (
      setup_w && !pwrite_i && mapped_w && index_w == pll_pkg::IDX_FB_HIGH
      |=> prdata_o == {27'h0, $past(fb_count_o[12:8])})
      else $error("feedback high bits read back wrong");

   ctrl_read_a: assert property (
      setup_w && !pwrite_i && mapped_w && index_w == pll_pkg::IDX_CTRL
      |=> prdata_o == {24'h000000, $past(ctrl_reg), 4'h0})
      else $error("control register read back wrong");

   rd_ctrl_c:    cover property (setup_w && !pwrite_i && index_w == pll_pkg::IDX_CTRL ##1 pready_o);
   ref_pulse_c:  cover property (pll_active_o && ref_div_pulse_o);
   swallow_c:    cover property (modulus_sel_o ##[1:20] fb_div_pulse_o);
   unmapped_c:   cover property (pready_o && pslverr_o);
   all_hold_c:   cover property (ref_div_reset_o && fb_div_reset_o);

endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the pll divider control register slice
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {logic [31:0] data; logic err; logic wr;} note_t;
   // design signals
   logic        clock_i, rstn_i, psel_i, penable_i, pwrite_i, ref_tick_i, vco_tick_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic        pready_o, pslverr_o, charge_pump_output_half_o, ref_div_reset_o, fb_div_reset_o;
   logic        pll_active_o, ref_div_pulse_o, fb_div_pulse_o, modulus_sel_o;
   logic [13:0] ref_count_o;
   logic [5:0]  swallow_count_o;
   logic [12:0] fb_count_o;
   // bench state
   note_t       q[$];
   int          error_cnt, compares, cycles, ref_pulses, fb_pulses;
   logic [7:0]  mask [7] = '{8'h03, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'h1f, 8'hf0};
   logic [7:0]  rstv [7] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
   logic [7:0]  val [7];
   logic [7:0]  ctl [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'hff};
   logic [7:0]  hold [4] = '{8'h00, 8'h10, 8'h40, 8'h20};
   logic [31:0] r;
   logic        sel_seen;

   pll_divider_control_regs #(.ADDR_W(12)) DUT (
      .clock_i(clock_i), .rstn_i(rstn_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .ref_tick_i(ref_tick_i), .vco_tick_i(vco_tick_i),
      .charge_pump_output_half_o(charge_pump_output_half_o), .ref_div_reset_o(ref_div_reset_o),
      .fb_div_reset_o(fb_div_reset_o), .pll_active_o(pll_active_o), .ref_count_o(ref_count_o),
      .swallow_count_o(swallow_count_o), .fb_count_o(fb_count_o), .ref_div_pulse_o(ref_div_pulse_o),
      .fb_div_pulse_o(fb_div_pulse_o), .modulus_sel_o(modulus_sel_o));

   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   task automatic chk_bus(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_out(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // one apb transfer; the note is queued for the watcher
   task automatic apb(input logic [9:0] idx, input logic [1:0] lo, input logic wr, input logic [31:0] wd,
                      input logic [31:0] exp, input logic err);
      q.push_back('{exp, err, wr});
      @(posedge clock_i);
      paddr_i   <= {idx, lo};
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= wr;
      pwdata_i  <= wd;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clock_i);
      end while (pready_o !== 1'b1);
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      apb(idx, 2'h0, 1'b1, d, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
      apb(idx, 2'h0, 1'b0, 32'h0, exp, 1'b0);
   endtask

   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask

   // watcher: each completed transfer retires the oldest note
   always @(posedge clock_i) begin
      note_t n;
      if (psel_i && penable_i && pready_o === 1'b1) begin
         n = q.pop_front();
         if (!n.wr) chk_bus("prdata", n.data, prdata_o);
         chk_bus("pslverr", {31'h0, n.err}, {31'h0, pslverr_o});
      end
   end

   always @(posedge clock_i) begin
      if (ref_div_pulse_o === 1'b1) ref_pulses++;
      if (fb_div_pulse_o === 1'b1) fb_pulses++;
      if (modulus_sel_o === 1'b1) sel_seen = 1'b1;
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         $display("wrong value run length expected below 20000 seen %0d", cycles);
         wrap_up();
      end
   end

   initial begin
      rstn_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
      paddr_i = 12'h000; pwdata_i = 32'h0; ref_tick_i = 1'b0; vco_tick_i = 1'b0;
      void'($urandom(32'h656e));
      repeat (8) @(posedge clock_i);
      rstn_i <= 1'b1;
      @(posedge clock_i);
      chk_out("ref_count", 32'h1, {18'h0, ref_count_o});
      chk_out("fb_count", 32'h3, {19'h0, fb_count_o});
      chk_out("pump_half", 32'h0, {31'h0, charge_pump_output_half_o});
      for (int i = 0; i < 7; i++) rd(pll_pkg::IDX_MODE + 10'(i), {24'h0, rstv[i]});
      done("reset values");
      for (int i = 1; i < 6; i++) begin
         r = $urandom;
         val[i] = r[7:0] & mask[i];
         wr(pll_pkg::IDX_MODE + 10'(i), r);
         rd(pll_pkg::IDX_MODE + 10'(i), {24'h0, val[i]});
      end
      chk_out("ref_count", {18'h0, val[2][5:0], val[1]}, {18'h0, ref_count_o});
      chk_out("swallow", {26'h0, val[3][5:0]}, {26'h0, swallow_count_o});
      chk_out("fb_count", {19'h0, val[5][4:0], val[4]}, {19'h0, fb_count_o});
      done("count registers");
      apb(10'h017, 2'h0, 1'b0, 32'h0, 32'h0, 1'b1);
      apb(10'h00f, 2'h0, 1'b1, 32'hff, 32'h0, 1'b1);
      apb(pll_pkg::IDX_REF_LOW, 2'h1, 1'b0, 32'h0, 32'h0, 1'b1);
      apb(pll_pkg::IDX_REF_LOW, 2'h2, 1'b1, {24'h0, ~val[1]}, 32'h0, 1'b1);
      rd(pll_pkg::IDX_REF_LOW, {24'h0, val[1]});
      done("unmapped access");
      foreach (ctl[i]) begin
         wr(pll_pkg::IDX_CTRL, ($urandom & 32'hffffff00) | {24'h0, ctl[i]});
         rd(pll_pkg::IDX_CTRL, {24'h0, ctl[i] & 8'hf0});
         repeat (3) @(posedge clock_i);
         chk_out("pump_half", {31'h0, ctl[i][7]}, {31'h0, charge_pump_output_half_o});
         chk_out("ref_hold", {31'h0, ctl[i][6] | ctl[i][4]}, {31'h0, ref_div_reset_o});
         chk_out("fb_hold", {31'h0, ctl[i][5] | ctl[i][4]}, {31'h0, fb_div_reset_o});
      end
      done("control bits");
      for (int m = 3; m >= 0; m--) begin
         wr(pll_pkg::IDX_MODE, ($urandom & 32'hfffffffc) | 32'(m));
         rd(pll_pkg::IDX_MODE, 32'(m));
         repeat (3) @(posedge clock_i);
         chk_out("pll_active", {31'h0, m == 0}, {31'h0, pll_active_o});
      end
      done("operating modes");
      wr(pll_pkg::IDX_REF_LOW, 32'h3);
      wr(pll_pkg::IDX_REF_HIGH, 32'h0);
      wr(pll_pkg::IDX_SWALLOW, 32'h2);
      wr(pll_pkg::IDX_FB_LOW, 32'h4);
      wr(pll_pkg::IDX_FB_HIGH, 32'h0);
      foreach (hold[i]) begin
         wr(pll_pkg::IDX_CTRL, {24'h0, hold[i]});
         repeat (3) @(posedge clock_i);
         ref_pulses = 0;
         fb_pulses = 0;
         sel_seen = 1'b0;
         ref_tick_i <= 1'b1;
         vco_tick_i <= 1'b1;
         repeat (24) @(posedge clock_i);
         ref_tick_i <= 1'b0;
         vco_tick_i <= 1'b0;
         repeat (4) @(posedge clock_i);
         chk_out("ref_pulses", (hold[i][6] | hold[i][4]) ? 32'h0 : 32'h8, 32'(ref_pulses));
         chk_out("fb_pulses", (hold[i][5] | hold[i][4]) ? 32'h0 : 32'h6, 32'(fb_pulses));
         chk_out("modulus_sel", {31'h0, !(hold[i][5] | hold[i][4])}, {31'h0, sel_seen});
      end
      done("divider holds");
      wrap_up();
   end
endmodule
